// ### design/dtic_defs.svh
// Register addresses, field positions and reset values of the deadline timer and command block
`ifndef DTIC_DEFS_SVH
`define DTIC_DEFS_SVH
`define DT_ADDR_TARGET   32'h0000_06E0
`define DT_ADDR_CMD_LO   32'hFFE0_0300
`define DT_ADDR_CMD_HI   32'hFFE0_0310
`define DT_ADDR_TMR_ENT  32'hFFE0_0320
`define DT_ADDR_INIT_CNT 32'hFFE0_0380
`define DT_ADDR_CUR_CNT  32'hFFE0_0390
`define DT_MODE_HI       18
`define DT_MODE_LO       17
`define DT_MODE_DEADLINE 2'h2
`define DT_MASK_BIT      16
`define DT_VEC_HI        7
`define DT_VEC_LO        0
`define DT_DLV_HI        10
`define DT_DLV_LO        8
`define DT_DST_MODE_BIT  11
`define DT_STATUS_BIT    12
`define DT_DEST_HI       31
`define DT_DEST_LO       24
`define DT_RST_TARGET    64'h0000_0000_0000_0000
`define DT_RST_WORD      32'h0000_0000
`define DT_RST_TMR_ENT   32'h0001_0000
`define DT_RST_VEC       8'h00
`define DT_IRR_BITS      256
`endif

// ### design/dtic_msg_sender.sv
// Interprocessor message launcher with delivery status
`timescale 1ns/1ps
`include "dtic_defs.svh"
module dtic_msg_sender
(
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   input  wire logic                  ce,
   input  wire logic                  launch,
   input  wire logic [63:0]           cmd,
   input  wire logic                  msg_ready,
   output dtic_pkg::dtic_kind_type    msg_kind_ff,
   output logic                       msg_valid_ff,
   output logic [7:0]                 msg_vector_ff,
   output logic [7:0]                 msg_dest_ff,
   output logic                       msg_dest_mode_ff,
   output logic                       busy_ff
);
   dtic_pkg::dtic_send_state_type state_ff;
   dtic_pkg::dtic_kind_type       kind;
   logic                          sendable;

   assign kind = dtic_pkg::dtic_kind_type'(cmd[`DT_DLV_HI:`DT_DLV_LO]);

   always_comb
   begin
      unique case (kind)
         dtic_pkg::DTIC_KIND_FIXED, dtic_pkg::DTIC_KIND_LOWEST, dtic_pkg::DTIC_KIND_MGMT,
         dtic_pkg::DTIC_KIND_NMI, dtic_pkg::DTIC_KIND_RESTART: sendable = 1'b1; // [RL17] [RL18] [RL19] [RL20] [RL21]
         default: sendable = 1'b0; // Reserved code 011 and codes 110, 111 are dropped [RL17]
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff         <= dtic_pkg::DTIC_SEND_IDLE;
         msg_valid_ff     <= 1'b0;
         busy_ff          <= 1'b0;
         msg_kind_ff      <= dtic_pkg::DTIC_KIND_FIXED;
         msg_vector_ff    <= `DT_RST_VEC;
         msg_dest_ff      <= `DT_RST_VEC;
         msg_dest_mode_ff <= 1'b0;
      end
      else if (ce)
      begin
         unique case (state_ff)
            dtic_pkg::DTIC_SEND_IDLE:
            begin
               if (launch && sendable)
               begin
                  state_ff         <= dtic_pkg::DTIC_SEND_BUSY;
                  msg_valid_ff     <= 1'b1;
                  busy_ff          <= 1'b1; // [RL22]
                  msg_kind_ff      <= kind;
                  msg_dest_ff      <= cmd[32+`DT_DEST_HI:32+`DT_DEST_LO];
                  msg_dest_mode_ff <= cmd[`DT_DST_MODE_BIT];
                  // Vector is ignored for the non-maskable kind
                  msg_vector_ff    <= (kind == dtic_pkg::DTIC_KIND_NMI) ? `DT_RST_VEC
                                      : cmd[`DT_VEC_HI:`DT_VEC_LO]; // [RL20]
               end
            end
            dtic_pkg::DTIC_SEND_BUSY:
            begin
               if (msg_ready)
               begin
                  state_ff     <= dtic_pkg::DTIC_SEND_IDLE;
                  msg_valid_ff <= 1'b0;
                  busy_ff      <= 1'b0; // [RL22]
               end
            end
         endcase
      end
   end

   AST_STATUS_TRACKS: assert property (@(posedge clock) disable iff (!rst_b) // [RL22]
      busy_ff && !(ce && msg_ready) |=> busy_ff) else $error("Delivery status dropped while pending");
   AST_NMI_NO_VEC: assert property (@(posedge clock) disable iff (!rst_b) // [RL20]
      msg_valid_ff && msg_kind_ff == dtic_pkg::DTIC_KIND_NMI |-> msg_vector_ff == 8'h00)
      else $error("Non-maskable message carries a vector");
   AST_NO_RSVD: assert property (@(posedge clock) disable iff (!rst_b) // [RL17]
      msg_valid_ff |-> msg_kind_ff != dtic_pkg::DTIC_KIND_RSVD) else $error("Reserved kind sent");
   CVR_RESTART: cover property (@(posedge clock) disable iff (!rst_b)
      msg_valid_ff && msg_ready && msg_kind_ff == dtic_pkg::DTIC_KIND_RESTART);
endmodule // dtic_msg_sender

// ### design/dtic_pkg.sv
// Types shared by the deadline timer and command block
package dtic_pkg;
   typedef enum logic [2:0] {
      DTIC_KIND_FIXED   = 3'h0,
      DTIC_KIND_LOWEST  = 3'h1,
      DTIC_KIND_MGMT    = 3'h2,
      DTIC_KIND_RSVD    = 3'h3,
      DTIC_KIND_NMI     = 3'h4,
      DTIC_KIND_RESTART = 3'h5,
      DTIC_KIND_OTHER6  = 3'h6,
      DTIC_KIND_OTHER7  = 3'h7
   } dtic_kind_type;
   typedef enum logic {
      DTIC_SEND_IDLE = 1'b0,
      DTIC_SEND_BUSY = 1'b1
   } dtic_send_state_type;
endpackage

// ### design/dtic_top.sv
// Deadline timer, local interrupt acceptance and interprocessor command register
`timescale 1ns/1ps
`include "dtic_defs.svh"
// Overview of operation
// RL1 - Deadline mode: ignore initial count, current reads zero
// RL2 - Non-zero target write arms the timer
// RL3 - Fire when stamp >= target, unsigned
// RL4 - Firing disarms and clears target
// RL5 - Zero target write disarms silently
// RL6 - Mode change into/out of deadline disarms
// RL7 - Target resets to zero
// RL8 - Mode bit 18 low: target reads zero, ignores writes
// RL9 - Mode field 10b selects deadline mode
// RL10 - Non-zero write replaces pending deadline
// RL11 - Software confirms interrupts against the stamp
// RL12 - Software re-writes large target until nonzero
// RL13 - Accepted interrupts logged pending, rejected retried
// RL14 - Command register: 64 bits, two halves
// RL15 - Low half write launches message
// RL16 - All command fields writable except status
// RL17 - Code 000 fixed, 011 reserved
// RL18 - Code 001 lowest priority delivery
// RL19 - Code 010 management, vector 00H
// RL20 - Code 100 non-maskable, vector ignored
// RL21 - Code 101 restart request, vector 00H
// RL22 - Status bit one while message pending
// RL23 - Mode change disarms; modes mutually exclusive
// RL24 - Stamp input compared every cycle while armed
module dtic_top
#(
   parameter int STAMP_W = 64
)
(
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   input  wire logic                  ce,
   input  wire logic [STAMP_W-1:0]    stamp,
   input  wire logic                  reg_wr_en,
   input  wire logic                  reg_rd_en,
   input  wire logic [31:0]           reg_addr,
   input  wire logic [63:0]           reg_wdata,
   output logic      [63:0]           reg_rdata_ff,
   output logic                       reg_rd_valid_ff,
   input  wire logic                  lint_accept,
   input  wire logic                  lint_reject,
   output logic                       lint_valid_ff,
   output logic      [7:0]            lint_vector_ff,
   input  wire logic                  svc_take,
   output logic                       svc_valid_ff,
   output logic      [7:0]            svc_vector_ff,
   input  wire logic                  msg_ready,
   output logic                       msg_valid_ff,
   output dtic_pkg::dtic_kind_type    msg_kind_ff,
   output logic      [7:0]            msg_vector_ff,
   output logic      [7:0]            msg_dest_ff,
   output logic                       msg_dest_mode_ff
);
   if (STAMP_W != 64)
   begin : g_stamp_w_check
      $error("Stamp width must be 64");
   end

   logic [STAMP_W-1:0]        target_ff;
   logic                      armed_ff;
   logic [31:0]               tmr_ent_ff;
   logic [31:0]               init_cnt_ff;
   logic [31:0]               cmd_lo_ff;
   logic [31:0]               cmd_hi_ff;
   logic [`DT_IRR_BITS-1:0]   irr_ff;
   logic                      busy_ff;
   logic                      wr_target;
   logic                      wr_ent;
   logic                      wr_lo;
   logic                      mode_change;
   logic                      deadline_mode;
   logic                      fire;
   logic [63:0]               nxt_rdata;
   logic                      irr_any;
   logic [7:0]                irr_top;
   logic [2:0]                wr_code;

   // Highest set pending bit
   function automatic logic [7:0] top_bit(input logic [`DT_IRR_BITS-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < `DT_IRR_BITS; i++)
         if (v[i])
            r = 8'(i);
      return r;
   endfunction

   assign deadline_mode = tmr_ent_ff[`DT_MODE_HI:`DT_MODE_LO] == `DT_MODE_DEADLINE; // [RL9] [RL23]
   assign wr_target     = reg_wr_en && reg_addr == `DT_ADDR_TARGET && tmr_ent_ff[`DT_MODE_HI]; // [RL8]
   assign wr_ent        = reg_wr_en && reg_addr == `DT_ADDR_TMR_ENT;
   assign wr_lo         = reg_wr_en && reg_addr == `DT_ADDR_CMD_LO;
   assign wr_code       = reg_wdata[`DT_DLV_HI:`DT_DLV_LO];
   assign mode_change   = wr_ent && (reg_wdata[`DT_MODE_HI:`DT_MODE_LO]
                          != tmr_ent_ff[`DT_MODE_HI:`DT_MODE_LO]);
   // Compared every cycle; a same-cycle target write takes precedence
   assign fire          = armed_ff && deadline_mode && !wr_target && !mode_change
                          && (stamp >= target_ff); // [RL3] [RL24]
   assign irr_any       = |irr_ff;
   assign irr_top       = top_bit(irr_ff);

   // Timer vector entry
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         tmr_ent_ff <= `DT_RST_TMR_ENT;
      else if (ce && wr_ent)
         tmr_ent_ff <= reg_wdata[31:0];
   end

   // Initial count, ignored in deadline mode
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         init_cnt_ff <= `DT_RST_WORD;
      else if (ce && reg_wr_en && reg_addr == `DT_ADDR_INIT_CNT && !deadline_mode)
         init_cnt_ff <= reg_wdata[31:0]; // [RL1]
   end

   // Deadline target and arm state
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         target_ff <= `DT_RST_TARGET; // [RL7]
         armed_ff  <= 1'b0;
      end
      else if (ce)
      begin
         if (mode_change)
            armed_ff <= 1'b0; // [RL6] [RL23]
         else if (wr_target)
         begin
            target_ff <= reg_wdata; // [RL10]
            armed_ff  <= (reg_wdata != `DT_RST_TARGET) && deadline_mode; // [RL2] [RL5]
         end
         else if (fire)
         begin
            target_ff <= `DT_RST_TARGET; // [RL4]
            armed_ff  <= 1'b0; // [RL4]
         end
      end
   end

   // Local interrupt offered to the core; a rejected one stays offered
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lint_valid_ff  <= 1'b0;
         lint_vector_ff <= `DT_RST_VEC;
      end
      else if (ce)
      begin
         if (fire && !tmr_ent_ff[`DT_MASK_BIT])
         begin
            lint_valid_ff  <= 1'b1;
            lint_vector_ff <= tmr_ent_ff[`DT_VEC_HI:`DT_VEC_LO];
         end
         else if (lint_valid_ff && lint_accept)
            lint_valid_ff <= 1'b0; // [RL13]
      end
   end

   // Request pending register and priority service
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         irr_ff <= '0;
      else if (ce)
      begin
         if (svc_valid_ff && svc_take)
            irr_ff[svc_vector_ff] <= 1'b0;
         if (lint_valid_ff && lint_accept && !lint_reject)
            irr_ff[lint_vector_ff] <= 1'b1; // [RL13]
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         svc_valid_ff  <= 1'b0;
         svc_vector_ff <= `DT_RST_VEC;
      end
      else if (ce)
      begin
         svc_valid_ff  <= irr_any && !(svc_valid_ff && svc_take); // [RL13]
         svc_vector_ff <= irr_top;
      end
   end

   // Command register halves; the status bit is stored but reads back as busy_ff
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_lo_ff <= `DT_RST_WORD;
         cmd_hi_ff <= `DT_RST_WORD;
      end
      else if (ce)
      begin
         if (wr_lo)
            cmd_lo_ff <= reg_wdata[31:0]; // [RL14] [RL16]
         if (reg_wr_en && reg_addr == `DT_ADDR_CMD_HI)
            cmd_hi_ff <= reg_wdata[31:0]; // [RL14] [RL16]
      end
   end

   dtic_msg_sender u_sender
   (
      .clock            (clock),
      .rst_b            (rst_b),
      .ce               (ce),
      .launch           (wr_lo), // [RL15]
      .cmd              ({cmd_hi_ff, reg_wdata[31:0]}),
      .msg_ready        (msg_ready),
      .msg_kind_ff      (msg_kind_ff),
      .msg_valid_ff     (msg_valid_ff),
      .msg_vector_ff    (msg_vector_ff),
      .msg_dest_ff      (msg_dest_ff),
      .msg_dest_mode_ff (msg_dest_mode_ff),
      .busy_ff          (busy_ff)
   );

   // Read data
   always_comb
   begin
      nxt_rdata = '0;
      unique case (reg_addr)
         `DT_ADDR_TARGET:
            if (tmr_ent_ff[`DT_MODE_HI])
               nxt_rdata = target_ff; // [RL8]
         `DT_ADDR_CMD_LO:
         begin
            nxt_rdata[31:0]            = cmd_lo_ff;
            nxt_rdata[`DT_STATUS_BIT]  = busy_ff; // [RL16] [RL22]
         end
         `DT_ADDR_CMD_HI:   nxt_rdata[31:0] = cmd_hi_ff;
         `DT_ADDR_TMR_ENT:  nxt_rdata[31:0] = tmr_ent_ff;
         `DT_ADDR_INIT_CNT: nxt_rdata[31:0] = init_cnt_ff;
         `DT_ADDR_CUR_CNT:
            if (!deadline_mode)
               nxt_rdata[31:0] = init_cnt_ff; // [RL1]
         default: nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata_ff    <= `DT_RST_TARGET;
         reg_rd_valid_ff <= 1'b0;
      end
      else if (ce)
      begin
         reg_rd_valid_ff <= reg_rd_en;
         if (reg_rd_en)
            reg_rdata_ff <= nxt_rdata;
      end
   end

   AST_CUR_ZERO: assert property (@(posedge clock) disable iff (!rst_b) // [RL1]
      ce && reg_rd_en && reg_addr == `DT_ADDR_CUR_CNT && deadline_mode |=> reg_rdata_ff == 64'h0)
      else $error("Current count not zero in deadline mode");

   AST_INIT_IGNORE: assert property (@(posedge clock) disable iff (!rst_b) // [RL1]
      ce && reg_wr_en && reg_addr == `DT_ADDR_INIT_CNT && deadline_mode |=> $stable(init_cnt_ff))
      else $error("Initial count written in deadline mode");

   AST_ARM: assert property (@(posedge clock) disable iff (!rst_b) // [RL2]
      ce && wr_target && deadline_mode && !mode_change && reg_wdata != 64'h0
      |=> armed_ff && target_ff == $past(reg_wdata))
      else $error("Non-zero target write did not arm");

   AST_ARMED_NONZERO: assert property (@(posedge clock) disable iff (!rst_b) // [RL2] [RL5]
      armed_ff |-> target_ff != 64'h0)
      else $error("Armed with zero target");

   AST_FIRE: assert property (@(posedge clock) disable iff (!rst_b) // [RL3] [RL4]
      ce && armed_ff && deadline_mode && !reg_wr_en && stamp >= target_ff && !tmr_ent_ff[`DT_MASK_BIT]
      |=> lint_valid_ff && !armed_ff && target_ff == 64'h0)
      else $error("Deadline reached without interrupt and clear");

   AST_MASKED: assert property (@(posedge clock) disable iff (!rst_b) // [RL4]
      ce && fire && tmr_ent_ff[`DT_MASK_BIT] && !lint_valid_ff |=> !lint_valid_ff && !armed_ff)
      else $error("Masked deadline offered");

   AST_ZERO_DISARM: assert property (@(posedge clock) disable iff (!rst_b) // [RL5]
      ce && wr_target && reg_wdata == 64'h0 && !lint_valid_ff |=> !armed_ff && !lint_valid_ff)
      else $error("Zero target write misbehaved");

   AST_MODE_DISARM: assert property (@(posedge clock) disable iff (!rst_b) // [RL6]
      ce && mode_change |=> !armed_ff)
      else $error("Mode change left timer armed");

   AST_ARMED_MODE: assert property (@(posedge clock) disable iff (!rst_b) // [RL23]
      armed_ff |-> deadline_mode)
      else $error("Armed outside deadline mode");

   AST_BIT18_READ: assert property (@(posedge clock) disable iff (!rst_b) // [RL8]
      ce && reg_rd_en && reg_addr == `DT_ADDR_TARGET && !tmr_ent_ff[`DT_MODE_HI] |=> reg_rdata_ff == 64'h0)
      else $error("Target readable outside deadline mode");

   AST_BIT18_WRITE: assert property (@(posedge clock) disable iff (!rst_b) // [RL8]
      ce && reg_wr_en && reg_addr == `DT_ADDR_TARGET && !tmr_ent_ff[`DT_MODE_HI] |=> $stable(target_ff))
      else $error("Target written outside deadline mode");

   AST_REPLACE: assert property (@(posedge clock) disable iff (!rst_b) // [RL10]
      ce && armed_ff && wr_target && deadline_mode && reg_wdata != 64'h0 |=> target_ff == $past(reg_wdata))
      else $error("Armed deadline not replaced");

   AST_ACCEPT_LOG: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
      ce && lint_valid_ff && lint_accept && !lint_reject |=> irr_ff[$past(lint_vector_ff)])
      else $error("Accepted interrupt not pending");

   AST_REJECT_HOLD: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
      ce && lint_valid_ff && lint_reject && !lint_accept |=> lint_valid_ff)
      else $error("Rejected interrupt not retried");

   AST_SVC_TOP: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
      svc_valid_ff |-> irr_ff[svc_vector_ff])
      else $error("Serviced vector not pending");

   AST_CMD_HI_RW: assert property (@(posedge clock) disable iff (!rst_b) // [RL14] [RL16]
      ce && reg_wr_en && reg_addr == `DT_ADDR_CMD_HI |=> cmd_hi_ff == 32'($past(reg_wdata)))
      else $error("High half not written");

   AST_LAUNCH: assert property (@(posedge clock) disable iff (!rst_b) // [RL15]
      ce && wr_lo && !busy_ff && wr_code == 3'h0 |=> msg_valid_ff && busy_ff)
      else $error("Low half write did not launch");

   AST_DEST: assert property (@(posedge clock) disable iff (!rst_b) // [RL15]
      ce && wr_lo && !busy_ff && wr_code == 3'h0 |=> msg_dest_ff == 8'($past(cmd_hi_ff) >> `DT_DEST_LO))
      else $error("Destination differs from high half");

   AST_KIND: assert property (@(posedge clock) disable iff (!rst_b) // [RL18] [RL19] [RL21]
      ce && wr_lo && !busy_ff && wr_code inside {3'h1, 3'h2, 3'h5}
      |=> msg_valid_ff && msg_kind_ff == $past(wr_code))
      else $error("Kind differs from delivery code");

   AST_RSVD_HOLD: assert property (@(posedge clock) disable iff (!rst_b) // [RL17]
      ce && wr_lo && !busy_ff && wr_code == 3'h3 |=> !msg_valid_ff)
      else $error("Reserved code launched");

   AST_STATUS_READ: assert property (@(posedge clock) disable iff (!rst_b) // [RL22]
      ce && reg_rd_en && reg_addr == `DT_ADDR_CMD_LO |=> reg_rdata_ff[`DT_STATUS_BIT] == $past(busy_ff))
      else $error("Delivery status read wrong");

   CVR_FIRE: cover property (@(posedge clock) disable iff (!rst_b) fire);
   CVR_MASKED_FIRE: cover property (@(posedge clock) disable iff (!rst_b) fire && tmr_ent_ff[`DT_MASK_BIT]);
   CVR_REPLACE: cover property (@(posedge clock) disable iff (!rst_b) armed_ff && wr_target);
   CVR_RETRY: cover property (@(posedge clock) disable iff (!rst_b)
      lint_valid_ff && lint_reject ##2 lint_valid_ff && lint_accept);
endmodule // dtic_top

// ### test/deadline_timer_and_ipi_command_tb_top.sv
// Testbench for the deadline timer and command block
`timescale 1ns/1ps
`include "dtic_defs.svh"
module deadline_timer_and_ipi_command_tb_top;
   logic                    clock = 1'b0;
   logic                    rst_b = 1'b0;
   logic                    ce = 1'b1;
   logic [63:0]             stamp = '0;
   logic                    reg_wr_en = 1'b0;
   logic                    reg_rd_en = 1'b0;
   logic [31:0]             reg_addr = '0;
   logic [63:0]             reg_wdata = '0;
   logic [63:0]             reg_rdata_ff;
   logic                    reg_rd_valid_ff;
   logic                    lint_accept, lint_reject, lint_valid_ff;
   logic [7:0]              lint_vector_ff, svc_vector_ff, msg_vector_ff, msg_dest_ff;
   logic                    svc_take, svc_valid_ff, msg_ready, msg_valid_ff, msg_dest_mode_ff;
   dtic_pkg::dtic_kind_type msg_kind_ff;
   int                      n_errors = 0;
   int                      checks_done = 0;
   int                      cycles = 0;
   logic [63:0]             d;
   always #50 clock = ~clock;
   dtic_top DUT (.clock(clock), .rst_b(rst_b), .ce(ce), .stamp(stamp), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .reg_rd_valid_ff(reg_rd_valid_ff), .lint_accept(lint_accept), .lint_reject(lint_reject),
      .lint_valid_ff(lint_valid_ff), .lint_vector_ff(lint_vector_ff), .svc_take(svc_take),
      .svc_valid_ff(svc_valid_ff), .svc_vector_ff(svc_vector_ff), .msg_ready(msg_ready),
      .msg_valid_ff(msg_valid_ff), .msg_kind_ff(msg_kind_ff), .msg_vector_ff(msg_vector_ff),
      .msg_dest_ff(msg_dest_ff), .msg_dest_mode_ff(msg_dest_mode_ff));
   dtic_core_model core (.clock(clock), .rst_b(rst_b), .lint_valid_ff(lint_valid_ff),
      .svc_valid_ff(svc_valid_ff), .msg_valid_ff(msg_valid_ff), .reject_cnt(4'h1), .ready_wait(4'h8),
      .lint_accept(lint_accept), .lint_reject(lint_reject), .svc_take(svc_take), .msg_ready(msg_ready));
   task automatic finish_test;
      $display("checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [63:0] v);
      @(negedge clock);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clock);
      reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [63:0] v);
      @(negedge clock);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge clock);
      reg_rd_en = 1'b0;
      chk(reg_rd_valid_ff, 1'b1);
      v = reg_rdata_ff;
   endtask
   task automatic set_stamp(input logic [63:0] v);
      @(negedge clock);
      stamp = v;
   endtask
   // Watch for an offer and its logging; expects both or neither
   task automatic fire(input logic exp, input logic [7:0] vec);
      logic       lseen, sseen;
      logic [7:0] lv, sv;
      lseen = 1'b0;
      sseen = 1'b0;
      lv = '0;
      sv = '0;
      repeat (16)
      begin
         @(posedge clock);
         #1;
         if (lint_valid_ff === 1'b1 && !lseen)
         begin
            lseen = 1'b1;
            lv = lint_vector_ff;
         end
         if (svc_valid_ff === 1'b1 && !sseen)
         begin
            sseen = 1'b1;
            sv = svc_vector_ff;
         end
      end
      chk(lseen, exp);
      chk(sseen, exp);
      if (exp)
      begin
         chk(lv, vec);
         chk(sv, vec);
      end
   endtask
   task automatic send(input logic [2:0] code);
      logic [7:0]  vec, dst;
      logic [31:0] lo;
      logic        seen, ok;
      int          i;
      vec = (code == 3'h2 || code == 3'h5) ? 8'h00 : 8'h55;
      dst = 8'h10 + code;
      lo = 32'h0000_0800 | (code << 8) | vec;
      ok = code inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
      seen = 1'b0;
      wr(`DT_ADDR_CMD_HI, {32'h0, dst, 24'h0});
      wr(`DT_ADDR_CMD_LO, {32'h0, lo | 32'h0000_1000});
      for (i = 0; i < 4 && !seen; i++)
      begin
         @(posedge clock);
         #1;
         seen = (msg_valid_ff === 1'b1);
      end
      chk(seen, ok);
      if (seen)
      begin
         chk(msg_kind_ff, code);
         chk(msg_vector_ff, (code == 3'h4) ? 8'h00 : vec);
         chk({msg_dest_mode_ff, msg_dest_ff}, {1'b1, dst});
         rd(`DT_ADDR_CMD_LO, d);
         chk(d[12], 1'b1);
         for (i = 0; i < 20 && msg_valid_ff !== 1'b0; i++)
            @(posedge clock);
      end
      rd(`DT_ADDR_CMD_LO, d);
      chk(d[31:0], lo);
      rd(`DT_ADDR_CMD_HI, d);
      chk(d[31:0], {dst, 24'h0});
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         finish_test();
      end
   end
   initial
   begin
      repeat (20) @(posedge clock);
      @(negedge clock);
      rst_b = 1'b1;
      rd(`DT_ADDR_TARGET, d);
      chk(d, `DT_RST_TARGET);
      wr(`DT_ADDR_TARGET, 64'h5);
      rd(`DT_ADDR_TARGET, d);
      chk(d, 64'h0);
      $display("test reset done");
      wr(`DT_ADDR_INIT_CNT, 64'h1234);
      wr(`DT_ADDR_TMR_ENT, 64'h0004_0040);
      wr(`DT_ADDR_INIT_CNT, 64'h5678);
      rd(`DT_ADDR_CUR_CNT, d);
      chk(d, 64'h0);
      rd(`DT_ADDR_INIT_CNT, d);
      chk(d, 64'h1234);
      d = '0;
      for (int k = 0; k < 4 && d == 0; k++)
      begin
         wr(`DT_ADDR_TARGET, 64'hFFFF_FFFF_0000_0000);
         rd(`DT_ADDR_TARGET, d);
      end
      chk(d, 64'hFFFF_FFFF_0000_0000);
      wr(`DT_ADDR_TARGET, 64'd100);
      rd(`DT_ADDR_TARGET, d);
      chk(d, 64'd100);
      ce = 1'b0;
      wr(`DT_ADDR_TARGET, 64'd7);
      ce = 1'b1;
      rd(`DT_ADDR_TARGET, d);
      chk(d, 64'd100);
      set_stamp(64'd99);
      fire(1'b0, 8'h40);
      set_stamp(64'd100);
      fire(1'b1, 8'h40);
      rd(`DT_ADDR_TARGET, d);
      chk(d, 64'h0);
      chk(stamp >= 64'd100 && d == 64'h0, 1'b1);
      fire(1'b0, 8'h40);
      $display("test deadline fire done");
      wr(`DT_ADDR_TARGET, 64'd200);
      wr(`DT_ADDR_TARGET, 64'd0);
      set_stamp(64'd300);
      fire(1'b0, 8'h40);
      wr(`DT_ADDR_TARGET, 64'd1000);
      wr(`DT_ADDR_TARGET, 64'd2000);
      set_stamp(64'd1500);
      fire(1'b0, 8'h40);
      set_stamp(64'd2000);
      fire(1'b1, 8'h40);
      wr(`DT_ADDR_TARGET, 64'd5000);
      wr(`DT_ADDR_TARGET, 64'd2500);
      set_stamp(64'd2500);
      fire(1'b1, 8'h40);
      $display("test disarm and replace done");
      wr(`DT_ADDR_TARGET, 64'd9000);
      wr(`DT_ADDR_TMR_ENT, 64'h0002_0040);
      rd(`DT_ADDR_TARGET, d);
      chk(d, 64'h0);
      wr(`DT_ADDR_TMR_ENT, 64'h0004_0040);
      set_stamp(64'd9000);
      fire(1'b0, 8'h40);
      wr(`DT_ADDR_TARGET, 64'h8000_0000_0000_0000);
      set_stamp(64'h7FFF_FFFF_FFFF_FFFF);
      fire(1'b0, 8'h40);
      set_stamp(64'h8000_0000_0000_0000);
      fire(1'b1, 8'h40);
      wr(`DT_ADDR_TMR_ENT, 64'h0005_0040);
      wr(`DT_ADDR_TARGET, 64'd5);
      fire(1'b0, 8'h40);
      rd(`DT_ADDR_TARGET, d);
      chk(d, 64'h0);
      $display("test mode change and wide compare done");
      for (int c = 0; c < 8; c++)
         send(c[2:0]);
      $display("test command messages done");
      finish_test();
   end
endmodule // deadline_timer_and_ipi_command_tb_top

// ### test/dtic_core_model.sv
// Behavioural core and far-end interrupt unit for the deadline timer and command block
`timescale 1ns/1ps
module dtic_core_model
(
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       lint_valid_ff,
   input  wire logic       svc_valid_ff,
   input  wire logic       msg_valid_ff,
   input  wire logic [3:0] reject_cnt,
   input  wire logic [3:0] ready_wait,
   output logic            lint_accept,
   output logic            lint_reject,
   output logic            svc_take,
   output logic            msg_ready
);
   int rej_seen;
   int wait_seen;
   // Answers change at the falling edge, one idle cycle between answers
   always @(negedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lint_accept <= 1'b0;
         lint_reject <= 1'b0;
         svc_take    <= 1'b0;
         msg_ready   <= 1'b0;
         rej_seen = 0;
         wait_seen = 0;
      end
      else
      begin
         lint_accept <= 1'b0;
         lint_reject <= 1'b0;
         svc_take    <= 1'b0;
         msg_ready   <= 1'b0;
         if (lint_valid_ff && !lint_accept && !lint_reject)
         begin
            if (rej_seen < reject_cnt)
            begin
               lint_reject <= 1'b1;
               rej_seen++;
            end
            else
            begin
               lint_accept <= 1'b1;
               rej_seen = 0;
            end
         end
         if (svc_valid_ff && !svc_take)
            svc_take <= 1'b1;
         if (msg_valid_ff && !msg_ready)
         begin
            if (wait_seen < ready_wait)
               wait_seen++;
            else
            begin
               msg_ready <= 1'b1;
               wait_seen = 0;
            end
         end
      end
   end
endmodule // dtic_core_model
